/* tgp_consts.vh */
// constants for the timer pin mux and external interrupt block
`ifndef TGP_CONSTS_VH
`define TGP_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define TGP_OFS_FUNC_SEL    8'h00
`define TGP_OFS_GPIO_DIR    8'h04
`define TGP_OFS_GPIO_DATA   8'h08
`define TGP_OFS_PIN_LEVEL   8'h0c
`define TGP_OFS_PORT_PUEN   8'h10
`define TGP_OFS_SYS_PUDIS   8'h14
`define TGP_OFS_IRQ_CFG     8'h18
`define TGP_OFS_INT_STATUS  8'h1c
`define TGP_OFS_INT_MASK    8'h20

// ****************************************
// widths and field positions
// ****************************************
`define TGP_NPIN            6
`define TGP_NIRQ            2
`define TGP_PIN_T3_CH0      0
`define TGP_PIN_T3_CH1      1
`define TGP_PIN_T4_CH0      2
`define TGP_PIN_T4_CH3      5
`define TGP_IRQ_A           0
`define TGP_IRQ_B           1
`define TGP_PUDIS_IRQ_BIT   0

// ****************************************
// reset values
// ****************************************
`define TGP_RST_FUNC_SEL    6'h00
`define TGP_RST_GPIO_DIR    6'h00
`define TGP_RST_GPIO_DATA   6'h00
`define TGP_RST_PORT_PUEN   6'h3f
`define TGP_RST_SYS_PUDIS   1'b0
`define TGP_RST_IRQ_CFG     2'h0
`define TGP_RST_INT_MASK    2'h0
`define TGP_RST_PAD_OUT     6'h00
`define TGP_RST_PAD_OE_N    6'h3f
`define TGP_RST_PIN_LEVEL   6'h00

// ****************************************
// timing counts
// ****************************************
`define TGP_SYNC_STAGES     2

`endif

/* tgp_irq_sense.v */
// sensing of one active-low external interrupt request input
`timescale 1ns/1ps
`include "tgp_consts.vh"

module tgp_irq_sense (
  input  wire clk,
  input  wire sys_rst,
  input  wire req_n,
  input  wire edge_mode,
  input  wire low_power,
  output wire req_event,
  output wire req_level,
  output wire wake
);

  reg sync_1;
  reg sync_2;
  reg prev_lvl;

  // two-flop synchroniser, first stage feeds only the second
  always @(posedge clk) begin
    if (sys_rst) begin
      sync_1 <= 1'b1;
      sync_2 <= 1'b1;
      prev_lvl <= 1'b1;
    end else begin
      sync_1 <= req_n; // [R7]
      sync_2 <= sync_1; // [R7]
      prev_lvl <= sync_2;
    end
  end

  // level mode asserts while low; edge mode fires on high-to-low only
  assign req_level = ~sync_2;
  assign req_event = edge_mode ? (prev_lvl & ~sync_2) : ~sync_2; // [R8]

  // raw pin path: needs no clock edge, so it works while the clock is stopped
  assign wake = low_power & ~req_n; // [R6]

endmodule

/* tgp_pins.v */
// port e timer/gpio pin mux with two external interrupt requests and apb registers
//
// Operation
// R1: timer 3 channels 0,1 on shared pins
// R2: timer 4 channels 0-3 on shared pins
// R3: per-pin gpio direction, input or output
// R4: reset selects timer function on all pins
// R5: cleared port pull-up bit disables pull-up
// R6: requests taken asynchronously in stop/wait
// R7: requests synchronised in all other modes
// R8: each request level or falling-edge sensed
// R9: system pull-up disable bit removes request pull-ups
// R10: external device holds request per sensing
// R11: one function-select bit per pin, reset timer
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "tgp_consts.vh"

module tgp_pins (
  input  wire        clk,
  input  wire        sys_rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // timer 3 channel side
  input  wire [1:0]  timer3_ch_out,
  input  wire [1:0]  timer3_ch_oe,
  output wire [1:0]  timer3_ch_in,
  // timer 4 channel side
  input  wire [3:0]  timer4_ch_out,
  input  wire [3:0]  timer4_ch_oe,
  output wire [3:0]  timer4_ch_in,
  // shared pins, bit 0 is port_e_bit8 up to bit 5 is port_e_bit13
  input  wire [5:0]  port_e_pin_in,
  output reg  [5:0]  port_e_pin_out,
  output reg  [5:0]  port_e_pin_oe_n,
  output wire [5:0]  port_e_pullup_en,
  // external interrupt requests, active low
  input  wire        ext_int_req_a_n,
  input  wire        ext_int_req_b_n,
  input  wire        low_power_mode,
  output wire        ext_int_pullup_en,
  output wire        ext_int_a_level,
  output wire        ext_int_b_level,
  output wire        wake_req,
  output wire        irq
);

  // ****************************************
  // register state
  // ****************************************
  reg  [5:0] func_sel;
  reg  [5:0] gpio_dir;
  reg  [5:0] gpio_data;
  reg  [5:0] port_pullup_enable_reg;
  reg        system_pullup_disable_reg;
  reg  [1:0] irq_cfg;
  reg  [1:0] int_status;
  reg  [1:0] int_mask;
  reg  [5:0] pin_level;
  reg  [1:0] status_taken;

  wire [1:0] irq_event;
  wire [1:0] irq_wake;
  wire [1:0] irq_lvl;
  wire [5:0] tmr_out;
  wire [5:0] tmr_oe;
  wire       setup_ph;
  wire       access_ph;
  wire       wr_en;
  wire       rd_status;
  reg        addr_hit;
  reg  [31:0] next_prdata;

  // ****************************************
  // apb decode
  // ****************************************
  // zero-wait slave: access phase always completes in one cycle
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready    = access_ph;
  assign pslverr   = access_ph & ~addr_hit;
  assign wr_en     = access_ph & pwrite & addr_hit;
  assign rd_status = access_ph & ~pwrite & (paddr == `TGP_OFS_INT_STATUS);

  // address map check, also forms the read mux
  always @* begin
    addr_hit    = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      `TGP_OFS_FUNC_SEL:   next_prdata[5:0] = func_sel;
      `TGP_OFS_GPIO_DIR:   next_prdata[5:0] = gpio_dir;
      `TGP_OFS_GPIO_DATA:  next_prdata[5:0] = gpio_data;
      `TGP_OFS_PIN_LEVEL:  next_prdata[5:0] = pin_level;
      `TGP_OFS_PORT_PUEN:  next_prdata[5:0] = port_pullup_enable_reg;
      `TGP_OFS_SYS_PUDIS:  next_prdata[0]   = system_pullup_disable_reg;
      `TGP_OFS_IRQ_CFG:    next_prdata[1:0] = irq_cfg;
      `TGP_OFS_INT_STATUS: next_prdata[1:0] = int_status;
      `TGP_OFS_INT_MASK:   next_prdata[1:0] = int_mask;
      default:             addr_hit = 1'b0;
    endcase
  end

  // read data captured in setup, so it stands through the access phase
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata       <= 32'h0000_0000;
      status_taken <= 2'h0;
    end else if (setup_ph && !pwrite) begin
      prdata       <= next_prdata;
      status_taken <= int_status;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // software-written configuration
  always @(posedge clk) begin
    if (sys_rst) begin
      func_sel                  <= `TGP_RST_FUNC_SEL; // [R4] [R11]
      gpio_dir                  <= `TGP_RST_GPIO_DIR;
      gpio_data                 <= `TGP_RST_GPIO_DATA;
      port_pullup_enable_reg    <= `TGP_RST_PORT_PUEN;
      system_pullup_disable_reg <= `TGP_RST_SYS_PUDIS;
      irq_cfg                   <= `TGP_RST_IRQ_CFG;
      int_mask                  <= `TGP_RST_INT_MASK;
    end else if (wr_en) begin
      case (paddr)
        `TGP_OFS_FUNC_SEL:  func_sel <= pwdata[5:0]; // [R11]
        `TGP_OFS_GPIO_DIR:  gpio_dir <= pwdata[5:0]; // [R3]
        `TGP_OFS_GPIO_DATA: gpio_data <= pwdata[5:0];
        `TGP_OFS_PORT_PUEN: port_pullup_enable_reg <= pwdata[5:0]; // [R5]
        `TGP_OFS_SYS_PUDIS:
          system_pullup_disable_reg <= pwdata[`TGP_PUDIS_IRQ_BIT]; // [R9]
        `TGP_OFS_IRQ_CFG:   irq_cfg <= pwdata[1:0]; // [R8]
        `TGP_OFS_INT_MASK:  int_mask <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // shared pin mux
  // ****************************************
  // gather both timers into one pin-ordered vector
  assign tmr_out = {timer4_ch_out, timer3_ch_out}; // [R1] [R2]
  assign tmr_oe  = {timer4_ch_oe, timer3_ch_oe}; // [R1] [R2]

  // pin inputs always reach the timers; on a gpio pin the timer output is just not driven
  assign timer3_ch_in = port_e_pin_in[`TGP_PIN_T3_CH1:`TGP_PIN_T3_CH0]; // [R1]
  assign timer4_ch_in = port_e_pin_in[`TGP_PIN_T4_CH3:`TGP_PIN_T4_CH0]; // [R2]

  // registered pad drive; one cycle of latency keeps pad outputs glitch free
  always @(posedge clk) begin
    if (sys_rst) begin
      port_e_pin_out  <= `TGP_RST_PAD_OUT;
      port_e_pin_oe_n <= `TGP_RST_PAD_OE_N; // pads released while reset is held
    end else begin
      port_e_pin_out  <= (func_sel & gpio_data) | (~func_sel & tmr_out); // [R11]
      port_e_pin_oe_n <= ~((func_sel & gpio_dir) | (~func_sel & tmr_oe)); // [R3] [R11]
    end
  end

  // pad level sampled for software; inputs treated as clock-synchronous
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_level <= `TGP_RST_PIN_LEVEL;
    end else begin
      pin_level <= port_e_pin_in;
    end
  end

  // port pull-ups follow their enable bits directly, request pull-ups the inverted disable bit
  assign port_e_pullup_en  = port_pullup_enable_reg; // [R5]
  assign ext_int_pullup_en = ~system_pullup_disable_reg; // [R9]

  // ****************************************
  // external interrupt requests
  // ****************************************
  // one sensing slice per request input
  tgp_irq_sense u_sense_a (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .req_n     (ext_int_req_a_n),
    .edge_mode (irq_cfg[`TGP_IRQ_A]),
    .low_power (low_power_mode),
    .req_event (irq_event[`TGP_IRQ_A]),
    .req_level (irq_lvl[`TGP_IRQ_A]),
    .wake      (irq_wake[`TGP_IRQ_A])
  );

  tgp_irq_sense u_sense_b (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .req_n     (ext_int_req_b_n),
    .edge_mode (irq_cfg[`TGP_IRQ_B]),
    .low_power (low_power_mode),
    .req_event (irq_event[`TGP_IRQ_B]),
    .req_level (irq_lvl[`TGP_IRQ_B]),
    .wake      (irq_wake[`TGP_IRQ_B])
  );

  // the wake path relies on the requester holding its level until serviced
  assign wake_req        = |irq_wake; // [R6] [R10]
  assign ext_int_a_level = irq_lvl[`TGP_IRQ_A]; // [R7]
  assign ext_int_b_level = irq_lvl[`TGP_IRQ_B]; // [R7]

  // ****************************************
  // interrupt status
  // ****************************************
  // read clears only bits returned to software; a new event wins over the clear
  always @(posedge clk) begin
    if (sys_rst) begin
      int_status <= 2'h0;
    end else begin
      int_status <= (int_status & ~(rd_status ? status_taken : 2'h0)) | irq_event; // [R8]
    end
  end

  assign irq = |(int_status & int_mask);

endmodule

/* tgp_pins_asserts.sv */
// concurrent checks on the port e pin mux and request inputs
`timescale 1ns/1ps
`include "tgp_consts.vh"
module tgp_pins_asserts (
  input wire        clk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [1:0]  timer3_ch_oe,
  input wire [1:0]  timer3_ch_in,
  input wire [3:0]  timer4_ch_oe,
  input wire [3:0]  timer4_ch_in,
  input wire [5:0]  port_e_pin_in,
  input wire [5:0]  port_e_pin_oe_n,
  input wire [5:0]  port_e_pullup_en,
  input wire        ext_int_req_a_n,
  input wire        ext_int_req_b_n,
  input wire        low_power_mode,
  input wire        ext_int_pullup_en,
  input wire        ext_int_a_level,
  input wire        ext_int_b_level,
  input wire        wake_req
);
  // ****
  // checks
  // ****
  wire wr = psel && penable && pwrite; // write taken at access edge
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  t3_route_a: assert property (timer3_ch_in == port_e_pin_in[1:0])
    else $error("timer3 input not from pad");
  t4_route_a: assert property (timer4_ch_in == port_e_pin_in[5:2])
    else $error("timer4 input not from pad");
  rst_timer_a: assert property ($fell(sys_rst) |=>
    port_e_pin_oe_n == ~$past({timer4_ch_oe, timer3_ch_oe}))
    else $error("timer not in control after reset");
  pullup_rst_a: assert property ($past(sys_rst) |-> port_e_pullup_en == 6'h3f)
    else $error("pull-ups off after reset");
  puen_write_a: assert property (wr && paddr == `TGP_OFS_PORT_PUEN |=>
    port_e_pullup_en == $past(pwdata[5:0]))
    else $error("pull-up enable not applied");
  pudis_write_a: assert property (wr && paddr == `TGP_OFS_SYS_PUDIS |=>
    ext_int_pullup_en == !$past(pwdata[0]))
    else $error("request pull-up not applied");
  async_wake_a: assert property (wake_req ==
    (low_power_mode && !(ext_int_req_a_n && ext_int_req_b_n)))
    else $error("wake not from request pins");
  sync_req_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    ext_int_a_level == !$past(ext_int_req_a_n, 2))
    else $error("request sync latency wrong");
  sync_req_b_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    ext_int_b_level == !$past(ext_int_req_b_n, 2))
    else $error("request b sync latency wrong");
endmodule
bind tgp_pins tgp_pins_asserts chk (.*);

/* tgp_ext_dev.sv */
// external devices on the shared pads and request inputs
`timescale 1ns/1ps
module tgp_ext_dev (
  input  wire       clk,
  input  wire [5:0] drv_en,
  input  wire [5:0] drv_val,
  input  wire [1:0] req,
  input  wire [5:0] port_e_pin_out,
  input  wire [5:0] port_e_pin_oe_n,
  input  wire [5:0] port_e_pullup_en,
  input  wire       ext_int_pullup_en,
  output wire [5:0] port_e_pin_in,
  output wire       ext_int_req_a_n,
  output wire       ext_int_req_b_n
);
  reg [5:0] last = 6'h00;
  reg [1:0] last_r = 2'h0;
  // undriven pad without pull-up flips every cycle, never a stale level
  assign port_e_pin_in = ~port_e_pin_oe_n & port_e_pin_out
    | port_e_pin_oe_n & drv_en & drv_val
    | port_e_pin_oe_n & ~drv_en & (port_e_pullup_en | ~last);
  // request held low for as long as service is wanted
  assign {ext_int_req_b_n, ext_int_req_a_n} =
    ~req & (ext_int_pullup_en ? 2'h3 : ~last_r);
  always @(posedge clk) begin
    last <= port_e_pin_in;
    last_r <= {ext_int_req_b_n, ext_int_req_a_n};
  end
endmodule

/* tgp_pins_bench.sv */
// self-checking bench for the port e pin mux and request inputs
`timescale 1ns/1ps
`include "tgp_consts.vh"
module tgp_pins_bench;
  reg         clk, sys_rst, psel, penable, pwrite, low_power_mode;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [1:0]  timer3_ch_out, timer3_ch_oe, req;
  reg  [3:0]  timer4_ch_out, timer4_ch_oe;
  reg  [5:0]  drv_en, drv_val;
  reg         err;
  wire [31:0] prdata;
  wire [1:0]  timer3_ch_in;
  wire [3:0]  timer4_ch_in;
  wire [5:0]  port_e_pin_in, port_e_pin_out, port_e_pin_oe_n, port_e_pullup_en;
  wire        pready, pslverr, ext_int_req_a_n, ext_int_req_b_n, ext_int_pullup_en;
  wire        ext_int_a_level, ext_int_b_level, wake_req, irq;
  integer     miscompares, tests_run, cyc;
  tgp_pins uut (.*);
  tgp_ext_dev dev (.*);
  // ****
  // helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // hang guard, a run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // waits on pready, no fixed wait count assumed
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
    end
  endtask
  task settle;
    repeat (4) @(negedge clk);
  endtask
  // ****
  // scenarios
  // ****
  task t_timer;
    begin
      settle;
      chk(port_e_pin_oe_n, 6'h16);
      chk(port_e_pin_out & 6'h29, 6'h09);
      chk(timer4_ch_in, 4'h7);
      chk(timer3_ch_in, 2'h3);
      rd_chk(`TGP_OFS_FUNC_SEL, 32'h0);
      chk(err, 1'b0);
      rd_chk(`TGP_OFS_PORT_PUEN, 32'h3f);
    end
  endtask
  task t_gpio;
    begin
      apb(1'b1, `TGP_OFS_FUNC_SEL, 32'h3f);
      apb(1'b1, `TGP_OFS_GPIO_DIR, 32'h15);
      apb(1'b1, `TGP_OFS_GPIO_DATA, 32'h3f);
      drv_en <= 6'h2a;
      drv_val <= 6'h28;
      settle;
      chk(port_e_pin_oe_n, 6'h2a);
      chk(port_e_pin_out & 6'h15, 6'h15);
      rd_chk(`TGP_OFS_PIN_LEVEL, 32'h3d);
      apb(1'b1, `TGP_OFS_FUNC_SEL, 32'h0);
      drv_en <= 6'h00;
      settle;
      chk(port_e_pin_oe_n, 6'h16);
    end
  endtask
  // a level, b falling edge, both unmasked
  task t_irq;
    begin
      apb(1'b1, `TGP_OFS_IRQ_CFG, 32'h2);
      apb(1'b1, `TGP_OFS_INT_MASK, 32'h3);
      req <= 2'h3;
      settle;
      chk(irq, 1'b1);
      rd_chk(`TGP_OFS_INT_STATUS, 32'h3);
      rd_chk(`TGP_OFS_INT_STATUS, 32'h1);
      req <= 2'h0;
      settle;
      apb(1'b0, `TGP_OFS_INT_STATUS, 32'h0);
      rd_chk(`TGP_OFS_INT_STATUS, 32'h0);
      chk(irq, 1'b0);
      apb(1'b1, `TGP_OFS_INT_MASK, 32'h0);
      req <= 2'h1;
      settle;
      chk(irq, 1'b0);
      chk(ext_int_a_level, 1'b1);
      rd_chk(`TGP_OFS_INT_STATUS, 32'h1);
      req <= 2'h0;
    end
  endtask
  task t_wake;
    begin
      @(posedge clk);
      low_power_mode <= 1'b1;
      settle;
      chk(wake_req, 1'b0);
      @(posedge clk);
      req <= 2'h2;
      settle;
      chk(wake_req, 1'b1);
      chk(ext_int_b_level, 1'b1);
      @(posedge clk);
      req <= 2'h0;
      low_power_mode <= 1'b0;
    end
  endtask
  // released pads without pull-ups toggle until the reset that follows
  task t_pull;
    begin
      apb(1'b1, `TGP_OFS_PORT_PUEN, 32'h0a);
      settle;
      chk(port_e_pullup_en, 6'h0a);
      apb(1'b1, `TGP_OFS_SYS_PUDIS, 32'h1);
      settle;
      chk(ext_int_pullup_en, 1'b0);
      rd_chk(8'h40, 32'h0);
      chk(err, 1'b1);
    end
  endtask
  // mid-run reset after gpio use must hand the pins back to the timers
  task t_reset;
    begin
      apb(1'b1, `TGP_OFS_FUNC_SEL, 32'h3f);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      settle;
      chk(port_e_pin_oe_n, 6'h16);
      chk(port_e_pullup_en, 6'h3f);
      chk(ext_int_pullup_en, 1'b1);
      rd_chk(`TGP_OFS_FUNC_SEL, 32'h0);
      rd_chk(`TGP_OFS_INT_STATUS, 32'h0);
    end
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, low_power_mode} = 5'h10;
    {paddr, pwdata, req, drv_en, drv_val} = 0;
    {timer3_ch_out, timer3_ch_oe, timer4_ch_out, timer4_ch_oe} = 12'hd6a;
    {miscompares, tests_run, cyc} = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_timer;
    t_gpio;
    t_irq;
    t_wake;
    t_pull;
    t_reset;
    complete_run;
  end
endmodule
